// [lcd_cmd_core.sv]
// command front end, reset state and drive level of the lcd driver
// Contract
// - reset low puts all control state initial
// - display off, vss level, normal, com normal
// - start line, page, column zero; forward
// - n-line drive off, count 01100
// - four-level grey mode, pattern x101x010
// - scroll mode and addresses cleared
// - duty 100000, start block first row
// - partial display off, rmw off
// - oscillator stopped, frequency select 0000
// - power zero, step clocks 101
// - voltage range, volume, gradient cleared
// - discharge only during reset, power save off
// - reset clears serial shift state
// - soft reset: page, column, rmw, parameter state only
// - classify transfers, execute on internal clock
// - serial bytes arrive msb first
// - display on/off from D0
// - display off drives chosen off level
// - off level: D0 0 ground, 1 mid
// - reverse flips ram bit polarity
`timescale 1ns/100ps
module lcd_cmd_core #(
  parameter logic [7:0] SOFT_RESET_CODE = 8'hF0, // arbitrary code
  parameter logic [7:0] RMW_ENTER_CODE  = 8'hF1  // arbitrary code
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  input  wire logic        cmdDataSelect,
  input  wire logic        rdStrobeN,
  input  wire logic        wrStrobeN,
  input  wire logic [7:0]  dataBus,
  input  wire logic        serClk,
  input  wire logic        serData,
  input  wire logic        serSelN,
  input  wire logic        ramBit,
  output logic      [1:0]  driveLevel,
  output logic             displayOn,
  output logic             dischargeOn,
  output logic             powerSave,
  output logic             oscRun
);
  localparam int PINS = 14;
  logic [PINS-1:0] pinMeta;
  logic [PINS-1:0] pinSync;
  logic [PINS-1:0] pinPrev;
  logic [1:0]  busMode;
  logic        offLevelMid;
  logic        reverseMode;
  logic        allOn;
  logic        comReverse;
  logic [8:0]  startLine;
  logic [5:0]  pageAddr;
  logic [7:0]  colAddr;
  logic        inputDirPage;
  logic        colReverse;
  logic        nLineEn;
  logic [4:0]  nLineCount;
  logic        grayMode4;
  logic [7:0]  grayPattern;
  logic [1:0]  scrollMode;
  logic [7:0]  scrollStart;
  logic [7:0]  scrollEnd;
  logic [7:0]  scrollLines;
  logic [5:0]  dutyReg;
  logic [5:0]  startBlock;
  logic        partialOn;
  logic [7:0]  partialStart;
  logic [7:0]  partialLines;
  logic        rmwActive;
  logic [3:0]  oscFreq;
  logic [4:0]  powerCtrl;
  logic [2:0]  stepUpClk;
  logic [2:0]  stepDownClk;
  logic [1:0]  vRange;
  logic [6:0]  volume;
  logic [2:0]  tempGrad;
  logic [7:0]  serShift;
  logic [2:0]  serCount;
  logic        pendValid;
  logic        pendA0;
  logic [7:0]  pendByte;
  logic [15:0] cmdCount;
  logic [15:0] readCount;
  lcd_pkg::lcd_param_t paramState;
  logic        a0Now;
  logic        rdNow;
  logic        wrNow;
  logic        a0Prev;
  logic        rdPrev;
  logic        wrPrev;
  logic [7:0]  dataPrev;
  logic        sclkNow;
  logic        sclkPrev;
  logic        sdatNow;
  logic        selNow;
  logic        parWrite;
  logic        parRead;
  logic        serBit;
  logic        serDone;
  logic        cmdHit;
  logic        softReset;
  logic [7:0]  next_serShift;

  // two-flop synchronisers for every pin input
  always_ff @(posedge clk_sys)
  begin
    pinMeta <= {cmdDataSelect, rdStrobeN, wrStrobeN, dataBus, serClk, serData, serSelN};
    pinSync <= pinMeta;
    pinPrev <= pinSync;
  end

  assign {a0Now, rdNow, wrNow} = pinSync[13:11];
  assign {a0Prev, rdPrev, wrPrev, dataPrev} = pinPrev[13:3];
  assign {sclkNow, sdatNow, selNow} = pinSync[2:0];
  assign sclkPrev = pinPrev[2];

  // transfer classification per bus mode
  always_comb
  begin
    parWrite = 1'b0;
    parRead  = 1'b0;
    unique case (busMode)
      lcd_pkg::MODE_80:
      begin
        parWrite = !wrPrev && wrNow;
        parRead  = !rdPrev && rdNow;
      end
      lcd_pkg::MODE_68:
      begin
        parWrite = rdPrev && !rdNow && !wrPrev;
        parRead  = rdPrev && !rdNow && wrPrev;
      end
      default:
      begin
        parWrite = 1'b0;
        parRead  = 1'b0;
      end
    endcase
  end

  assign serBit = (busMode == lcd_pkg::MODE_SERIAL) && !selNow && !sclkPrev && sclkNow;
  assign serDone = serBit && (serCount == 3'd7);
  assign next_serShift = {serShift[6:0], sdatNow};

  // serial shift logic
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || selNow)
    begin
      serShift <= 8'h00;
      serCount <= 3'd0;
    end
    else if (serBit)
    begin
      serShift <= next_serShift;
      serCount <= serCount + 3'd1;
    end
  end

  // byte held one cycle, then run on the internal clock
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      pendValid <= 1'b0;
      pendA0    <= 1'b0;
      pendByte  <= 8'h00;
    end
    else
    begin
      pendValid <= parWrite || serDone;
      if (parWrite)
      begin
        pendA0   <= a0Prev;
        pendByte <= dataPrev;
      end
      else if (serDone)
      begin
        pendA0   <= a0Now;
        pendByte <= next_serShift;
      end
    end
  end

  assign cmdHit    = pendValid && !pendA0;
  assign softReset = cmdHit && (pendByte == SOFT_RESET_CODE);

  // display control flags
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      displayOn   <= 1'b0;
      offLevelMid <= 1'b0;
      reverseMode <= 1'b0;
      allOn       <= 1'b0;
      comReverse  <= 1'b0;
    end
    else if (cmdHit)
    begin
      if (pendByte[7:1] == lcd_pkg::OP_DISP_ONOFF) displayOn <= pendByte[0];
      if (pendByte[7:1] == lcd_pkg::OP_OFF_LEVEL) offLevelMid <= pendByte[0];
      if (pendByte[7:1] == lcd_pkg::OP_REVERSE) reverseMode <= pendByte[0];
      if (pendByte[7:1] == lcd_pkg::OP_ALL_ON) allOn <= pendByte[0];
      if (pendByte[7:1] == lcd_pkg::OP_COM_DIR) comReverse <= pendByte[0];
    end
  end

  // ram addresses, parameter bytes and rmw mode
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      pageAddr   <= lcd_pkg::RST_PAGE;
      colAddr    <= lcd_pkg::RST_COLUMN;
      rmwActive  <= 1'b0;
      paramState <= lcd_pkg::PAR_NONE;
    end
    else if (softReset)
    begin
      pageAddr   <= lcd_pkg::RST_PAGE;
      colAddr    <= lcd_pkg::RST_COLUMN;
      rmwActive  <= 1'b0;
      paramState <= lcd_pkg::PAR_NONE;
    end
    else if (pendValid)
    begin
      if (!pendA0)
      begin
        if (pendByte == RMW_ENTER_CODE) rmwActive <= 1'b1;
        if (pendByte == lcd_pkg::OP_PAGE_SET) paramState <= lcd_pkg::PAR_PAGE;
        else if (pendByte == lcd_pkg::OP_COL_SET) paramState <= lcd_pkg::PAR_COL;
        else paramState <= lcd_pkg::PAR_NONE;
      end
      else
      begin
        unique case (paramState)
          lcd_pkg::PAR_PAGE: pageAddr <= pendByte[5:0];
          lcd_pkg::PAR_COL:  colAddr <= pendByte;
          lcd_pkg::PAR_NONE: ;
          default: ;
        endcase
        paramState <= lcd_pkg::PAR_NONE;
      end
    end
  end

  // state set only by hardware reset here
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      startLine    <= lcd_pkg::RST_START_LINE;
      inputDirPage <= 1'b0;
      colReverse   <= 1'b0;
      nLineEn      <= 1'b0;
      nLineCount   <= lcd_pkg::RST_NLINE;
      grayMode4    <= 1'b1;
      grayPattern  <= lcd_pkg::RST_GRAY_PAT;
      scrollMode   <= lcd_pkg::RST_SCROLL_MOD;
      scrollStart  <= lcd_pkg::RST_SCROLL_ADR;
      scrollEnd    <= lcd_pkg::RST_SCROLL_ADR;
      scrollLines  <= lcd_pkg::RST_SCROLL_ADR;
      dutyReg      <= lcd_pkg::RST_DUTY;
      startBlock   <= lcd_pkg::RST_BLOCK;
      partialOn    <= 1'b0;
      partialStart <= lcd_pkg::RST_PARTIAL;
      partialLines <= lcd_pkg::RST_PARTIAL;
      oscRun       <= 1'b0;
      oscFreq      <= lcd_pkg::RST_OSC_FREQ;
      powerCtrl    <= lcd_pkg::RST_POWER;
      stepUpClk    <= lcd_pkg::RST_STEP_CLK;
      stepDownClk  <= lcd_pkg::RST_STEP_CLK;
      vRange       <= lcd_pkg::RST_VRANGE;
      volume       <= lcd_pkg::RST_VOLUME;
      tempGrad     <= lcd_pkg::RST_TEMP_GRAD;
      powerSave    <= 1'b0;
    end
  end

  assign dischargeOn = !rstn;

  // segment drive level from ram bit
  always_ff @(posedge clk_sys)
  begin
    if (!rstn) driveLevel <= lcd_pkg::LVL_VSS;
    else if (!displayOn)
      driveLevel <= offLevelMid ? lcd_pkg::LVL_VC : lcd_pkg::LVL_VSS;
    else if (allOn || (ramBit ^ reverseMode)) driveLevel <= lcd_pkg::LVL_ON;
    else driveLevel <= lcd_pkg::LVL_UNSEL;
  end

  // control register and transfer counters
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      busMode   <= lcd_pkg::CTRL_RESET;
      cmdCount  <= 16'h0000;
      readCount <= 16'h0000;
    end
    else
    begin
      if (regWr && regAddr == lcd_pkg::REG_CTRL) busMode <= regWdata[1:0];
      if (cmdHit) cmdCount <= cmdCount + 16'h0001;
      if (parRead) readCount <= readCount + 16'h0001;
    end
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge clk_sys)
  begin
    if (!rstn) regRdata <= 32'h0000_0000;
    else if (regRd)
    begin
      unique case (regAddr)
        lcd_pkg::REG_CTRL:    regRdata <= {30'h0, busMode};
        lcd_pkg::REG_STATUS:  regRdata <= {22'h0, paramState, rmwActive, oscRun, powerSave,
                                           comReverse, allOn, reverseMode, offLevelMid,
                                           displayOn};
        lcd_pkg::REG_ADDR:    regRdata <= {14'h0, colReverse, inputDirPage, colAddr,
                                           2'h0, pageAddr};
        lcd_pkg::REG_SCAN:    regRdata <= {11'h0, startLine, dutyReg, startBlock};
        lcd_pkg::REG_GRAY:    regRdata <= {17'h0, grayMode4, nLineEn, nLineCount, grayPattern};
        lcd_pkg::REG_SCROLL:  regRdata <= {6'h0, scrollMode, scrollLines, scrollEnd,
                                           scrollStart};
        lcd_pkg::REG_POWER:   regRdata <= {1'b0, tempGrad, volume, vRange, oscFreq,
                                           stepDownClk, stepUpClk, powerCtrl, 3'h0, oscRun};
        lcd_pkg::REG_PARTIAL: regRdata <= {15'h0, partialOn, partialLines, partialStart};
        lcd_pkg::REG_COUNT:   regRdata <= {readCount, cmdCount};
        default:              regRdata <= 32'h0000_0000;
      endcase
    end
    else regRdata <= 32'h0000_0000;
  end

  // checks
  resetDisplay_a: assert property (@(posedge clk_sys) !rstn |=>
    !displayOn && !offLevelMid && !reverseMode && !allOn && !comReverse)
    else $error("display flags not initial after reset");
  resetAddr_a: assert property (@(posedge clk_sys) !rstn |=>
    startLine == 9'h000 && pageAddr == 6'h00 && colAddr == 8'h00 && !inputDirPage && !colReverse)
    else $error("addresses not initial after reset");
  resetGray_a: assert property (@(posedge clk_sys) !rstn |=>
    !nLineEn && nLineCount == 5'b01100 && grayMode4 && grayPattern[6:4] == 3'b101
    && grayPattern[2:0] == 3'b010)
    else $error("grey or n-line state wrong after reset");
  resetScroll_a: assert property (@(posedge clk_sys) !rstn |=>
    scrollMode == 2'b00 && {scrollStart, scrollEnd, scrollLines} == 24'h00_0000
    && dutyReg == 6'b100000 && startBlock == 6'h00 && !partialOn
    && partialStart == 8'h00 && partialLines == 8'h00 && !rmwActive)
    else $error("scroll, duty or partial state wrong after reset");
  resetPower_a: assert property (@(posedge clk_sys) !rstn |=>
    !oscRun && oscFreq == 4'h0 && powerCtrl == 5'h00 && stepUpClk == 3'b101
    && stepDownClk == 3'b101 && vRange == 2'h0 && volume == 7'h00 && tempGrad == 3'h0)
    else $error("power state wrong after reset");
  dischargeLevel_a: assert property (@(posedge clk_sys)
    (dischargeOn == !rstn) and (!rstn |=> !powerSave))
    else $error("discharge not tied to reset");
  serialClear_a: assert property (@(posedge clk_sys) !rstn |=>
    serCount == 3'd0 && serShift == 8'h00)
    else $error("serial shift not cleared by reset");
  softReset_a: assert property (@(posedge clk_sys) disable iff (!rstn) softReset |=>
    pageAddr == 6'h00 && colAddr == 8'h00 && !rmwActive && $stable(displayOn)
    && $stable(reverseMode) && $stable(offLevelMid) && $stable(startLine))
    else $error("soft reset touched wrong state");
  writeToExec_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    parWrite && !a0Prev && dataPrev[7:1] == lcd_pkg::OP_DISP_ONOFF |=> ##1
    displayOn == $past(dataPrev[0], 2))
    else $error("parallel command not executed two cycles later");
  serialOrder_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    serDone |=> pendValid && pendByte[0] == $past(sdatNow) && pendByte[7:1] == $past(serShift[6:0]))
    else $error("serial byte not assembled msb first");
  dispCmd_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmdHit && pendByte[7:1] == 7'b1010111 |=> displayOn == $past(pendByte[0]))
    else $error("display on/off command not applied");
  offDrive_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !displayOn |=> driveLevel == ($past(offLevelMid) ? lcd_pkg::LVL_VC : lcd_pkg::LVL_VSS))
    else $error("display off level wrong");
  reverseDrive_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    displayOn && !allOn |=> driveLevel == (($past(ramBit) ^ $past(reverseMode))
    ? lcd_pkg::LVL_ON : lcd_pkg::LVL_UNSEL))
    else $error("polarity of ram bit wrong");
  nearMiss_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!cmdHit || pendByte[7:1] != 7'b1010111) |=> $stable(displayOn))
    else $error("display changed without exact opcode");
  coverDispOn_c: cover property (@(posedge clk_sys) cmdHit && pendByte == 8'hAF);
  coverSerial_c: cover property (@(posedge clk_sys) serDone);
  coverSoftReset_c: cover property (@(posedge clk_sys) softReset && pageAddr != 6'h00);
  coverOffMid_c: cover property (@(posedge clk_sys) driveLevel == lcd_pkg::LVL_VC);
endmodule

// [lcd_cmd_core_tb.sv]
// self-checking bench for the lcd command core
`timescale 1ns/100ps
module lcd_cmd_core_tb;
  localparam logic [7:0] SoftCode = 8'hF0;
  localparam logic [7:0] RmwCode  = 8'hF1;
  logic        clk_sys;
  logic        rstn;
  logic [3:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdata;
  logic        cmdDataSelect;
  logic        rdStrobeN;
  logic        wrStrobeN;
  logic [7:0]  dataBus;
  logic        serClk;
  logic        serData;
  logic        serSelN;
  logic        ramBit;
  logic [1:0]  driveLevel;
  logic        displayOn;
  logic        dischargeOn;
  logic        powerSave;
  logic        oscRun;
  logic [1:0]  curMode;
  logic [31:0] rdVal;
  int          error_cnt;
  int          n_checks;
  lcd_cmd_core #(.SOFT_RESET_CODE(SoftCode), .RMW_ENTER_CODE(RmwCode)) lcd_cmd_core_inst (
    .clk_sys, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .cmdDataSelect,
    .rdStrobeN, .wrStrobeN, .dataBus, .serClk, .serData, .serSelN, .ramBit,
    .driveLevel, .displayOn, .dischargeOn, .powerSave, .oscRun
  );
  lcd_host_model lcd_host_model_inst (
    .clk_sys, .cmdDataSelect, .rdStrobeN, .wrStrobeN, .dataBus, .serClk, .serData, .serSelN
  );
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic complete_run;
    if (error_cnt == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic regRead(input logic [3:0] a);
    @(posedge clk_sys);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(negedge clk_sys);
    rdVal = regRdata;
  endtask
  task automatic rdChk(input logic [3:0] a, input logic [31:0] exp);
    regRead(a);
    chk(rdVal, exp);
  endtask
  task automatic setMode(input logic [1:0] m);
    // idle levels settle before the mode switch, so no false strobe edge
    lcd_host_model_inst.idle(m);
    regWrite(lcd_pkg::REG_CTRL, {30'h0, m});
    curMode = m;
  endtask
  task automatic cmd(input logic a0, input logic [7:0] d);
    case (curMode)
      lcd_pkg::MODE_68:     lcd_host_model_inst.xfer68(1'b0, a0, d);
      lcd_pkg::MODE_SERIAL: lcd_host_model_inst.shift(a0, d, 8, 1'b0);
      default:              lcd_host_model_inst.xfer80(1'b0, a0, d);
    endcase
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic lvlChk(input logic rb, input lcd_pkg::lcd_level_t exp);
    @(posedge clk_sys);
    ramBit <= rb;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(32'(driveLevel), 32'(exp));
  endtask
  task automatic hwReset;
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(32'(dischargeOn), 32'h1);
    chk(32'(driveLevel), 32'(lcd_pkg::LVL_VSS));
    @(posedge clk_sys);
    rstn <= 1'b1;
    @(negedge clk_sys);
    chk(32'(dischargeOn), 32'h0);
    curMode = lcd_pkg::MODE_80;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic resetState;
    rdChk(lcd_pkg::REG_CTRL, 32'h0);
    rdChk(lcd_pkg::REG_STATUS, 32'h0);
    rdChk(lcd_pkg::REG_ADDR, 32'h0);
    rdChk(lcd_pkg::REG_SCAN, 32'h0000_0800);
    rdChk(lcd_pkg::REG_GRAY, 32'h0000_4C52);
    rdChk(lcd_pkg::REG_SCROLL, 32'h0);
    rdChk(lcd_pkg::REG_POWER, 32'h0000_5A00);
    rdChk(lcd_pkg::REG_PARTIAL, 32'h0);
    chk(32'(driveLevel), 32'(lcd_pkg::LVL_VSS));
    chk({29'h0, displayOn, powerSave, oscRun}, 32'h0);
  endtask
  task automatic displayCmds;
    cmd(1'b0, 8'hAF);
    chk(32'(displayOn), 32'h1);
    lvlChk(1'b1, lcd_pkg::LVL_ON);
    lvlChk(1'b0, lcd_pkg::LVL_UNSEL);
    cmd(1'b0, 8'hA7);
    lvlChk(1'b0, lcd_pkg::LVL_ON);
    lvlChk(1'b1, lcd_pkg::LVL_UNSEL);
    cmd(1'b0, 8'hA6);
    cmd(1'b0, 8'hBF);
    cmd(1'b0, 8'hAE);
    chk(32'(displayOn), 32'h0);
    lvlChk(1'b1, lcd_pkg::LVL_VC);
    cmd(1'b0, 8'hBE);
    lvlChk(1'b1, lcd_pkg::LVL_VSS);
    rdChk(lcd_pkg::REG_STATUS, 32'h0);
  endtask
  task automatic opcodeExact;
    logic [31:0] cnt;
    setMode(lcd_pkg::MODE_80);
    cmd(1'b0, 8'hAF);
    cmd(1'b0, 8'hEE);
    cmd(1'b0, 8'h2E);
    cmd(1'b1, 8'hAE);
    chk(32'(displayOn), 32'h1);
    regRead(lcd_pkg::REG_COUNT);
    cnt = rdVal;
    lcd_host_model_inst.xfer80(1'b1, 1'b1, 8'h00);
    rdChk(lcd_pkg::REG_COUNT, cnt + 32'h0001_0000);
    setMode(lcd_pkg::MODE_68);
    lcd_host_model_inst.xfer68(1'b1, 1'b1, 8'h00);
    cmd(1'b0, 8'hAE);
    rdChk(lcd_pkg::REG_COUNT, cnt + 32'h0002_0001);
    setMode(lcd_pkg::MODE_SERIAL);
    cmd(1'b0, 8'hAF);
    lcd_host_model_inst.xfer80(1'b0, 1'b0, 8'hAE);
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(32'(displayOn), 32'h1);
  endtask
  task automatic serialOrder;
    lcd_host_model_inst.shift(1'b0, 8'h00, 3, 1'b0);
    cmd(1'b0, 8'hAE);
    chk(32'(displayOn), 32'h0);
    cmd(1'b0, 8'hF5);
    chk(32'(displayOn), 32'h0);
    lcd_host_model_inst.shift(1'b0, 8'hFF, 4, 1'b1);
    hwReset;
    resetState;
    setMode(lcd_pkg::MODE_SERIAL);
    cmd(1'b0, 8'hAF);
    chk(32'(displayOn), 32'h1);
  endtask
  task automatic softReset;
    setMode(lcd_pkg::MODE_80);
    cmd(1'b0, 8'hA7);
    cmd(1'b0, lcd_pkg::OP_PAGE_SET);
    cmd(1'b1, 8'h1F);
    cmd(1'b0, lcd_pkg::OP_COL_SET);
    cmd(1'b1, 8'h9F);
    cmd(1'b0, RmwCode);
    rdChk(lcd_pkg::REG_ADDR, 32'h0000_9F1F);
    rdChk(lcd_pkg::REG_STATUS, 32'h0000_0085);
    cmd(1'b0, SoftCode);
    rdChk(lcd_pkg::REG_ADDR, 32'h0);
    rdChk(lcd_pkg::REG_STATUS, 32'h0000_0005);
    rdChk(lcd_pkg::REG_SCAN, 32'h0000_0800);
    regWrite(lcd_pkg::REG_STATUS, 32'hFFFF_FFFF);
    rdChk(lcd_pkg::REG_STATUS, 32'h0000_0005);
    cmd(1'b0, 8'hA5);
    cmd(1'b0, 8'hC5);
    rdChk(lcd_pkg::REG_STATUS, 32'h0000_001D);
    lvlChk(1'b1, lcd_pkg::LVL_ON);
    rdChk(4'h9, 32'h0);
  endtask
  initial
  begin
    rstn      = 1'b0;
    regAddr   = 4'h0;
    regWdata  = 32'h0;
    regWr     = 1'b0;
    regRd     = 1'b0;
    ramBit    = 1'b0;
    curMode   = lcd_pkg::MODE_80;
    error_cnt = 0;
    n_checks  = 0;
    hwReset;
    resetState;
    for (int m = 0; m < 3; m++)
    begin
      setMode(2'(m));
      displayCmds;
    end
    opcodeExact;
    serialOrder;
    softReset;
    complete_run;
  end
  // hang guard
  initial
  begin
    repeat (50000) @(posedge clk_sys);
    error_cnt++;
    complete_run;
  end
endmodule

// [lcd_host_model.sv]
// host processor pin model for the lcd command core
`timescale 1ns/100ps
module lcd_host_model (
  input  wire logic       clk_sys,
  output logic            cmdDataSelect,
  output logic            rdStrobeN,
  output logic            wrStrobeN,
  output logic [7:0]      dataBus,
  output logic            serClk,
  output logic            serData,
  output logic            serSelN
);
  initial
  begin
    cmdDataSelect = 1'b1;
    rdStrobeN     = 1'b1;
    wrStrobeN     = 1'b1;
    dataBus       = 8'h00;
    serClk        = 1'b0;
    serData       = 1'b0;
    serSelN       = 1'b1;
  end
  task automatic gap(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // released lines show the inverse so stale values never look valid
  task automatic drop(input logic a0, input logic [7:0] d);
    dataBus       <= ~d;
    cmdDataSelect <= ~a0;
  endtask
  task automatic idle(input logic [1:0] mode);
    @(posedge clk_sys);
    rdStrobeN <= (mode != lcd_pkg::MODE_68);
    wrStrobeN <= 1'b1;
    gap(4);
  endtask
  task automatic xfer80(input logic rd, input logic a0, input logic [7:0] d);
    @(posedge clk_sys);
    cmdDataSelect <= a0;
    dataBus       <= d;
    rdStrobeN     <= !rd;
    wrStrobeN     <= rd;
    gap(4);
    rdStrobeN <= 1'b1;
    wrStrobeN <= 1'b1;
    gap(3);
    drop(a0, d);
  endtask
  task automatic xfer68(input logic rd, input logic a0, input logic [7:0] d);
    @(posedge clk_sys);
    cmdDataSelect <= a0;
    dataBus       <= d;
    wrStrobeN     <= rd;
    gap(2);
    rdStrobeN <= 1'b1;
    gap(4);
    rdStrobeN <= 1'b0;
    gap(3);
    wrStrobeN <= 1'b1;
    drop(a0, d);
  endtask
  // clock stands low outside frames; hold keeps the frame open
  task automatic shift(input logic a0, input logic [7:0] d, input int nb, input logic hold);
    @(posedge clk_sys);
    serSelN       <= 1'b0;
    cmdDataSelect <= a0;
    for (int i = 7; i > 7 - nb; i--)
    begin
      serData <= d[i];
      serClk  <= 1'b0;
      gap(4);
      serClk <= 1'b1;
      gap(4);
    end
    serClk <= 1'b0;
    gap(3);
    if (!hold)
    begin
      serSelN       <= 1'b1;
      serData       <= ~d[8-nb];
      cmdDataSelect <= ~a0;
    end
  endtask
endmodule

// [lcd_pkg.sv]
// constants for the lcd command front end and reset state
package lcd_pkg;
  // register port offsets
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h1;
  localparam logic [3:0] REG_ADDR    = 4'h2;
  localparam logic [3:0] REG_SCAN    = 4'h3;
  localparam logic [3:0] REG_GRAY    = 4'h4;
  localparam logic [3:0] REG_SCROLL  = 4'h5;
  localparam logic [3:0] REG_POWER   = 4'h6;
  localparam logic [3:0] REG_PARTIAL = 4'h7;
  localparam logic [3:0] REG_COUNT   = 4'h8;
  // bus mode field of the control register
  localparam logic [1:0] MODE_80     = 2'h0;
  localparam logic [1:0] MODE_68     = 2'h1;
  localparam logic [1:0] MODE_SERIAL = 2'h2;
  localparam logic [1:0] CTRL_RESET  = 2'h0;
  // opcode bits D7..D1 of the flag commands; page and column set are full D7..D0 bytes
  localparam logic [6:0] OP_DISP_ONOFF = 7'h57;
  localparam logic [6:0] OP_OFF_LEVEL  = 7'h5F;
  localparam logic [6:0] OP_REVERSE    = 7'h53;
  localparam logic [6:0] OP_ALL_ON     = 7'h52;
  localparam logic [6:0] OP_COM_DIR    = 7'h62;
  localparam logic [7:0] OP_PAGE_SET   = 8'hB1;
  localparam logic [7:0] OP_COL_SET    = 8'h13;
  // reset values
  localparam logic [8:0] RST_START_LINE = 9'h000;
  localparam logic [5:0] RST_PAGE       = 6'h00;
  localparam logic [7:0] RST_COLUMN     = 8'h00;
  localparam logic [4:0] RST_NLINE      = 5'h0C;
  localparam logic [7:0] RST_GRAY_PAT   = 8'h52;
  localparam logic [1:0] RST_SCROLL_MOD = 2'h0;
  localparam logic [7:0] RST_SCROLL_ADR = 8'h00;
  localparam logic [5:0] RST_DUTY       = 6'h20;
  localparam logic [5:0] RST_BLOCK      = 6'h00;
  localparam logic [7:0] RST_PARTIAL    = 8'h00;
  localparam logic [3:0] RST_OSC_FREQ   = 4'h0;
  localparam logic [4:0] RST_POWER      = 5'h00;
  localparam logic [2:0] RST_STEP_CLK   = 3'h5;
  localparam logic [1:0] RST_VRANGE     = 2'h0;
  localparam logic [6:0] RST_VOLUME     = 7'h00;
  localparam logic [2:0] RST_TEMP_GRAD  = 3'h0;
  // driver output levels and parameter byte states
  typedef enum logic [1:0] {LVL_UNSEL, LVL_ON, LVL_VSS, LVL_VC} lcd_level_t;
  typedef enum logic [1:0] {PAR_NONE, PAR_PAGE, PAR_COL} lcd_param_t;
endpackage
